/* pkg/vsdc_map.vh */
// Register map, field positions and reset values for the video stream debug checker
//
// Notes on behaviour
// (RULE1) Flag line short when end-of-line comes early
// (RULE2) Flag line long when line overruns size
// (RULE3) Flag frame early or late against size
// (RULE4) Hold input ready low during init, flush
// (RULE5) No output during first two lines processed
// (RULE6) Discard surplus pixels until input line end
// (RULE7) Output start on user bit 0, end on last
// (RULE8) Control bit 4 enables passthrough when built
// (RULE9) Passthrough forwards input samples straight through muxes
// (RULE10) Passthrough puts sample on green, others zero
// (RULE11) Control bit 5 enables pattern generator when built
// (RULE12) Pattern pixels replace normal result at output
// (RULE13) Color bars on first 256 lines, 64 wide
// (RULE14) Bar order black red green yellow blue magenta cyan white
// (RULE15) Remaining lines carry a monochrome diagonal ramp
// (RULE16) Software clears passthrough from input toward output
// (RULE17) Software clears pattern from output toward input
// (RULE18) Debug features optional at build time
// (RULE19) Early frame start restarts; late one drops data
// (RULE20) Early line end ends line; late drops pixels
// (RULE21) Pattern wins over passthrough when both set
`ifndef VSDC_MAP_VH
`define VSDC_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define VSDC_ADDR_W          5
`define VSDC_REG_CONTROL     5'h00
`define VSDC_REG_STATUS      5'h04
`define VSDC_REG_ERROR       5'h08
`define VSDC_REG_ACTIVE_SIZE 5'h0C

// ****************************************
// Fields
// ****************************************
`define VSDC_CTRL_BYPASS     4
`define VSDC_CTRL_PATTERN    5
`define VSDC_ERR_LINE_SHORT  0
`define VSDC_ERR_LINE_LONG   1
`define VSDC_ERR_FRAME_EARLY 2
`define VSDC_ERR_FRAME_LATE  3
`define VSDC_SIZE_W          13
`define VSDC_HSIZE_LSB       0
`define VSDC_VSIZE_LSB       16

// ****************************************
// Reset values and counts
// ****************************************
`define VSDC_CONTROL_RST     32'h0000_0000
`define VSDC_ACTIVE_SIZE_RST 32'h0438_0780
`define VSDC_INIT_CYCLES     256
`define VSDC_WARM_LINES      2
`define VSDC_BAR_LINES       256
`define VSDC_BAR_SHIFT       6

`endif

/* rtl/vsdc_regs.v */
// Avalon-MM register slave of the video stream debug checker
`timescale 1ns/1ps
`include "vsdc_map.vh"
module vsdc_regs (
	input  wire                       ref_clk,
	input  wire                       rst_b,
	input  wire [`VSDC_ADDR_W-1:0]    avs_address,
	input  wire                       avs_read,
	input  wire                       avs_write,
	input  wire [31:0]                avs_writedata,
	input  wire [3:0]                 avs_byteenable,
	output reg  [31:0]                avs_readdata,
	output wire                       avs_waitrequest,
	input  wire [3:0]                 status_in,
	input  wire [3:0]                 err_set,
	output wire                       ctrl_bypass,
	output wire                       ctrl_pattern,
	output wire [`VSDC_SIZE_W-1:0]    hsize,
	output wire [`VSDC_SIZE_W-1:0]    vsize
);

	reg  [31:0] control;
	reg  [31:0] active_size;
	reg  [3:0]  error_flags;
	reg         ack;
	wire        req;
	wire        wr_now;
	wire [31:0] be_mask;

	function [31:0] be_expand;
		input [3:0] be;
		be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// ****************************************
	// Bus handshake: one wait cycle per access
	// ****************************************
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack;
	assign wr_now          = avs_write & ack;
	assign be_mask         = be_expand(avs_byteenable);

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack          <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack <= req & ~ack;
			if (avs_read & ~ack) begin
				case (avs_address)
				`VSDC_REG_CONTROL:     avs_readdata <= control;
				`VSDC_REG_STATUS:      avs_readdata <= {28'h000_0000, status_in};
				`VSDC_REG_ERROR:       avs_readdata <= {28'h000_0000, error_flags};
				`VSDC_REG_ACTIVE_SIZE: avs_readdata <= active_size;
				default:               avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Storage; error flags clear by writing one
	// ****************************************
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			control     <= `VSDC_CONTROL_RST;
			active_size <= `VSDC_ACTIVE_SIZE_RST;
			error_flags <= 4'h0;
		end else begin
			if (wr_now && avs_address == `VSDC_REG_CONTROL)
				control <= (control & ~be_mask) | (avs_writedata & be_mask & 32'h0000_0030);
			if (wr_now && avs_address == `VSDC_REG_ACTIVE_SIZE)
				active_size <= (active_size & ~be_mask) | (avs_writedata & be_mask & 32'h1FFF_1FFF);
			// Set wins over a clear in the same cycle
			if (wr_now && avs_address == `VSDC_REG_ERROR && avs_byteenable[0])
				error_flags <= (error_flags & ~avs_writedata[3:0]) | err_set; // RULE1 RULE2 RULE3
			else
				error_flags <= error_flags | err_set; // RULE1 RULE2 RULE3
		end
	end

	assign ctrl_bypass  = control[`VSDC_CTRL_BYPASS];
	assign ctrl_pattern = control[`VSDC_CTRL_PATTERN];
	assign hsize        = active_size[`VSDC_HSIZE_LSB +: `VSDC_SIZE_W];
	assign vsize        = active_size[`VSDC_VSIZE_LSB +: `VSDC_SIZE_W];

endmodule // vsdc_regs

/* rtl/vsdc_pattern_gen.v */
// Color-bar and ramp test-pattern generator
`timescale 1ns/1ps
`include "vsdc_map.vh"
module vsdc_pattern_gen #(
	parameter DW = 8
) (
	input  wire                       ref_clk,
	input  wire                       rst_b,
	input  wire                       active,
	input  wire                       advance,
	input  wire [`VSDC_SIZE_W-1:0]    hsize,
	input  wire [`VSDC_SIZE_W-1:0]    vsize,
	output wire [DW-1:0]              pat_r,
	output wire [DW-1:0]              pat_g,
	output wire [DW-1:0]              pat_b,
	output wire                       pat_last,
	output wire                       pat_sof
);

	reg  [`VSDC_SIZE_W-1:0] x;
	reg  [`VSDC_SIZE_W-1:0] y;
	wire [2:0]              bar;
	wire                    in_bars;
	wire [`VSDC_SIZE_W-1:0] ramp;
	wire [`VSDC_SIZE_W-1:0] bar_lines;
	localparam [`VSDC_SIZE_W-1:0] BAR_LINES = `VSDC_BAR_LINES;

	// ****************************************
	// Position counters
	// ****************************************
	assign bar_lines = BAR_LINES;
	assign pat_last  = (x == hsize - 13'h0001);
	assign pat_sof   = (x == 13'h0000) && (y == 13'h0000);

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			x <= 13'h0000;
			y <= 13'h0000;
		end else if (!active) begin
			// Idle at frame origin so enabling starts a clean frame
			x <= 13'h0000;
			y <= 13'h0000;
		end else if (advance) begin
			if (pat_last) begin
				x <= 13'h0000;
				y <= (y == vsize - 13'h0001) ? 13'h0000 : y + 13'h0001;
			end else begin
				x <= x + 13'h0001;
			end
		end
	end

	// ****************************************
	// Pixel colour
	// ****************************************
	assign in_bars = (y < bar_lines); // RULE13
	assign bar     = x[`VSDC_BAR_SHIFT +: 3]; // RULE13 RULE14
	assign ramp    = x + y; // RULE15
	// Bar code bit 0 red, bit 1 green, bit 2 blue gives the bar order
	assign pat_r = in_bars ? {DW{bar[0]}} : ramp[DW-1:0]; // RULE14 RULE15
	assign pat_g = in_bars ? {DW{bar[1]}} : ramp[DW-1:0]; // RULE14 RULE15
	assign pat_b = in_bars ? {DW{bar[2]}} : ramp[DW-1:0]; // RULE14 RULE15

endmodule // vsdc_pattern_gen

/* rtl/vsdc_top.v */
// Framing checker, passthrough and test pattern on the video stream path
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "vsdc_map.vh"
module vsdc_top #(
	parameter DW            = 8,
	parameter INCLUDE_DEBUG = 1,
	parameter INIT_CYCLES   = `VSDC_INIT_CYCLES
) (
	input  wire                       ref_clk,
	input  wire                       rst_b,
	input  wire [`VSDC_ADDR_W-1:0]    avs_address,
	input  wire                       avs_read,
	input  wire                       avs_write,
	input  wire [31:0]                avs_writedata,
	input  wire [3:0]                 avs_byteenable,
	output wire [31:0]                avs_readdata,
	output wire                       avs_waitrequest,
	input  wire [DW-1:0]              s_axis_tdata,
	input  wire                       s_axis_tvalid,
	output wire                       s_axis_tready,
	input  wire                       s_axis_tlast,
	input  wire                       s_axis_tuser,
	output reg  [3*DW-1:0]            m_axis_tdata,
	output reg                        m_axis_tvalid,
	input  wire                       m_axis_tready,
	output reg                        m_axis_tlast,
	output reg                        m_axis_tuser
);

	// ****************************************
	// Framing states
	// ****************************************
	localparam ST_INIT  = 3'h0;
	localparam ST_SYNC  = 3'h1;
	localparam ST_RUN   = 3'h2;
	localparam ST_LDROP = 3'h3;
	localparam ST_FLUSH = 3'h4;
	localparam [15:0] INIT_LAST = INIT_CYCLES - 1;

	// ****************************************
	// Declarations
	// ****************************************
	reg  [2:0]              state;
	reg  [2:0]              next_state;
	reg  [`VSDC_SIZE_W-1:0] pix;
	reg  [`VSDC_SIZE_W-1:0] next_pix;
	reg  [`VSDC_SIZE_W-1:0] line;
	reg  [`VSDC_SIZE_W-1:0] next_line;
	reg  [15:0]             init_cnt;
	reg  [1:0]              warm;
	reg                     take;
	reg                     emit;
	reg                     o_last;
	reg                     o_sof;
	reg                     line_done;
	reg  [3:0]              err_set;
	reg  [`VSDC_SIZE_W-1:0] bp;
	reg  [`VSDC_SIZE_W-1:0] bl;
	reg                     load_valid;
	reg  [3*DW-1:0]         load_data;
	reg                     load_last;
	reg                     load_sof;

	// ****************************************
	// Internal nets
	// ****************************************
	wire                    ctrl_bypass;
	wire                    ctrl_pattern;
	wire [`VSDC_SIZE_W-1:0] hsize;
	wire [`VSDC_SIZE_W-1:0] vsize;
	wire [`VSDC_SIZE_W-1:0] hs1;
	wire [`VSDC_SIZE_W-1:0] vs1;
	wire                    out_free;
	wire                    in_fire;
	wire                    at_start;
	wire                    warm_ok;
	wire                    bypass_on;
	wire                    pattern_on;
	wire                    gen_advance;
	wire [DW-1:0]           pat_r;
	wire [DW-1:0]           pat_g;
	wire [DW-1:0]           pat_b;
	wire                    pat_last;
	wire                    pat_sof;
	wire [15:0]             init_last;

	// ****************************************
	// Helpers
	// ****************************************
	// Pack red, green and blue into one stream word, green lowest
	function [3*DW-1:0] pack_rgb;
		input [DW-1:0] r;
		input [DW-1:0] g;
		input [DW-1:0] b;
		pack_rgb = {r, b, g};
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	vsdc_regs u_regs (
		.ref_clk         (ref_clk),
		.rst_b           (rst_b),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.status_in       ({warm_ok, state == ST_LDROP, state == ST_SYNC, state == ST_INIT}),
		.err_set         (err_set),
		.ctrl_bypass     (ctrl_bypass),
		.ctrl_pattern    (ctrl_pattern),
		.hsize           (hsize),
		.vsize           (vsize)
	);

	// Debug controls only count when the features are built in
	assign bypass_on  = (INCLUDE_DEBUG != 0) & ctrl_bypass; // RULE8 RULE18
	assign pattern_on = (INCLUDE_DEBUG != 0) & ctrl_pattern; // RULE11 RULE18

	// ****************************************
	// Stream handshake
	// ****************************************
	assign hs1       = hsize - 13'h0001;
	assign vs1       = vsize - 13'h0001;
	assign init_last = INIT_LAST;
	assign out_free  = ~m_axis_tvalid | m_axis_tready;
	// Input waits while clearing or closing a cut-short frame
	assign s_axis_tready = (state != ST_INIT) & (state != ST_FLUSH) & out_free; // RULE4
	assign in_fire   = s_axis_tvalid & s_axis_tready;
	assign at_start  = (pix == 13'h0000) && (line == 13'h0000);
	assign warm_ok   = (warm == `VSDC_WARM_LINES);

	// ****************************************
	// Framing decisions per input beat
	// ****************************************
	always @* begin
		next_state = state;
		next_pix   = pix;
		next_line  = line;
		take       = 1'b0;
		emit       = 1'b0;
		o_last     = 1'b0;
		o_sof      = 1'b0;
		line_done  = 1'b0;
		err_set    = 4'h0;
		bp         = pix;
		bl         = line;
		case (state)
		ST_INIT: begin
			if (init_cnt == init_last)
				next_state = ST_SYNC;
		end
		ST_FLUSH: begin
			next_state = ST_RUN;
		end
		ST_SYNC, ST_RUN, ST_LDROP: begin
			if (in_fire) begin
				if (s_axis_tuser) begin
					// A frame start always restarts the frame at once
					take = 1'b1;
					bp   = 13'h0000;
					bl   = 13'h0000;
					if (state != ST_SYNC && !at_start) begin
						err_set[`VSDC_ERR_FRAME_EARLY] = 1'b1; // RULE3 RULE19
						next_state = ST_FLUSH; // RULE19
					end else begin
						next_state = ST_RUN;
					end
				end else if (state == ST_SYNC) begin
					next_state = ST_SYNC; // RULE19
				end else if (state == ST_LDROP) begin
					err_set[`VSDC_ERR_LINE_LONG] = 1'b1; // RULE2
					if (s_axis_tlast)
						next_state = ST_RUN; // RULE6 RULE20
				end else if (at_start) begin
					err_set[`VSDC_ERR_FRAME_LATE] = 1'b1; // RULE3
					next_state = ST_SYNC; // RULE19
				end else begin
					take = 1'b1;
				end
			end
		end
		default: begin
			next_state = ST_INIT;
		end
		endcase
		if (take) begin
			emit   = 1'b1;
			o_sof  = (bp == 13'h0000) && (bl == 13'h0000); // RULE7
			o_last = s_axis_tlast | (bp == hs1); // RULE7 RULE20
			if (s_axis_tlast && bp < hs1)
				err_set[`VSDC_ERR_LINE_SHORT] = 1'b1; // RULE1
			if (!s_axis_tlast && bp == hs1 && next_state == ST_RUN)
				next_state = ST_LDROP; // RULE6 RULE20
			if (o_last) begin
				line_done = 1'b1;
				next_pix  = 13'h0000;
				next_line = (bl == vs1) ? 13'h0000 : bl + 13'h0001;
			end else begin
				next_pix  = bp + 13'h0001;
				next_line = bl;
			end
		end
	end

	// ****************************************
	// State, counters and warm-up
	// ****************************************
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= ST_INIT;
			pix      <= 13'h0000;
			line     <= 13'h0000;
			init_cnt <= 16'h0000;
			warm     <= 2'h0;
		end else begin
			state <= next_state;
			pix   <= next_pix;
			line  <= next_line;
			if (state == ST_INIT)
				init_cnt <= init_cnt + 16'h0001;
			if (line_done && !warm_ok)
				warm <= warm + 2'h1; // RULE5
		end
	end

	// ****************************************
	// Test-pattern generator
	// ****************************************
	generate
		if (INCLUDE_DEBUG != 0) begin : g_pattern
			vsdc_pattern_gen #(
				.DW (DW)
			) u_pattern (
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.active   (pattern_on),
				.advance  (gen_advance),
				.hsize    (hsize),
				.vsize    (vsize),
				.pat_r    (pat_r),
				.pat_g    (pat_g),
				.pat_b    (pat_b),
				.pat_last (pat_last),
				.pat_sof  (pat_sof)
			);
		end else begin : g_no_pattern
			// Leaving the generator out saves its counters
			assign pat_r    = {DW{1'b0}}; // RULE18
			assign pat_g    = {DW{1'b0}};
			assign pat_b    = {DW{1'b0}};
			assign pat_last = 1'b0;
			assign pat_sof  = 1'b0;
		end
	endgenerate

	assign gen_advance = pattern_on & out_free & (state != ST_INIT);

	// ****************************************
	// Output source select
	// ****************************************
	always @* begin
		if (pattern_on) begin
			// Pattern has priority over passthrough
			load_valid = (state != ST_INIT); // RULE12 RULE21
			load_data  = pack_rgb(pat_r, pat_g, pat_b); // RULE12
			load_last  = pat_last;
			load_sof   = pat_sof;
		end else if (bypass_on) begin
			// No framing, warm-up or dropping on this path
			load_valid = in_fire; // RULE9
			load_data  = pack_rgb({DW{1'b0}}, s_axis_tdata, {DW{1'b0}}); // RULE10
			load_last  = s_axis_tlast; // RULE9
			load_sof   = s_axis_tuser; // RULE9
		end else begin
			load_valid = emit & warm_ok; // RULE5
			load_data  = pack_rgb({DW{1'b0}}, s_axis_tdata, {DW{1'b0}});
			load_last  = o_last; // RULE7
			load_sof   = o_sof; // RULE7
		end
	end

	// ****************************************
	// Output register
	// ****************************************
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			m_axis_tvalid <= 1'b0;
			m_axis_tdata  <= {3*DW{1'b0}};
			m_axis_tlast  <= 1'b0;
			m_axis_tuser  <= 1'b0;
		end else if (out_free) begin
			m_axis_tvalid <= load_valid;
			m_axis_tdata  <= load_data;
			m_axis_tlast  <= load_last;
			m_axis_tuser  <= load_sof;
		end
	end

endmodule // vsdc_top

/* verification/vsdc_properties.sv */
// Port checker for the video stream debug checker
`timescale 1ns/1ps
`include "vsdc_map.vh"
module vsdc_properties #(
	parameter DW          = 8,
	parameter INIT_CYCLES = 8
) (
	input logic                    ref_clk,
	input logic                    rst_b,
	input logic [`VSDC_ADDR_W-1:0] avs_address,
	input logic                    avs_read,
	input logic                    avs_write,
	input logic [31:0]             avs_writedata,
	input logic [3:0]              avs_byteenable,
	input logic [31:0]             avs_readdata,
	input logic                    avs_waitrequest,
	input logic [DW-1:0]           s_axis_tdata,
	input logic                    s_axis_tvalid,
	input logic                    s_axis_tready,
	input logic                    s_axis_tlast,
	input logic                    s_axis_tuser,
	input logic [3*DW-1:0]         m_axis_tdata,
	input logic                    m_axis_tvalid,
	input logic                    m_axis_tready,
	input logic                    m_axis_tlast,
	input logic                    m_axis_tuser
);
	// ****
	// Shadow of control, size and pattern position
	// ****
	logic [1:0]  ctl;
	logic [12:0] hs, vs, px, py;
	logic [15:0] age;
	wire         wr_ok = avs_write && !avs_waitrequest;
	wire         beat  = m_axis_tvalid && m_axis_tready;
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl <= 2'h0;
			hs  <= 13'h0780;
			vs  <= 13'h0438;
			px  <= 13'h0000;
			py  <= 13'h0000;
			age <= 16'h0000;
		end else begin
			if (age != 16'hFFFF)
				age <= age + 16'h0001;
			if (wr_ok && avs_address == `VSDC_REG_CONTROL && avs_byteenable[0])
				ctl <= avs_writedata[5:4];
			if (wr_ok && avs_address == `VSDC_REG_ACTIVE_SIZE) begin
				hs <= avs_writedata[12:0];
				vs <= avs_writedata[28:16];
			end
			// Generator restarts at origin whenever pattern is off
			if (!ctl[1]) begin
				px <= 13'h0000;
				py <= 13'h0000;
			end else if (beat) begin
				px <= (px == hs - 13'h0001) ? 13'h0000 : px + 13'h0001;
				if (px == hs - 13'h0001)
					py <= (py == vs - 13'h0001) ? 13'h0000 : py + 13'h0001;
			end
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_req_rise; $rose(avs_read || avs_write); endsequence
	sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
	sequence s_pass_take; ctl == 2'h1 && s_axis_tvalid && s_axis_tready; endsequence
	a_bus_one_wait: assert property (s_req_rise |-> s_one_wait) else $error("bus wait not one cycle");
	a_init_ready_low: assert property (age < INIT_CYCLES |-> !s_axis_tready) else $error("ready during init");
	a_init_ready_up: assert property (age == INIT_CYCLES + 1 |-> s_axis_tready) else $error("ready stuck low");
	a_out_hold: assert property (m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid
		&& $stable(m_axis_tdata) && $stable(m_axis_tlast) && $stable(m_axis_tuser))
		else $error("output beat not held");
	a_pass_green: assert property (ctl == 2'h1 && m_axis_tvalid |-> m_axis_tdata[3*DW-1:DW] == 0)
		else $error("red or blue not zero");
	a_pass_fwd: assert property (s_pass_take |=> m_axis_tvalid
		&& m_axis_tdata[DW-1:0] == $past(s_axis_tdata)
		&& m_axis_tlast == $past(s_axis_tlast) && m_axis_tuser == $past(s_axis_tuser))
		else $error("passthrough beat lost");
	a_pat_last: assert property (ctl[1] && m_axis_tvalid
		|-> m_axis_tlast == (px == hs - 13'h0001)) else $error("pattern line end misplaced");
	a_pat_black: assert property (ctl[1] && m_axis_tvalid && py < 256
		&& px[8:6] == 3'h0 |-> m_axis_tdata == 0) else $error("first bar not black");
	a_pat_ramp: assert property (ctl[1] && m_axis_tvalid && py >= 256
		|-> m_axis_tdata[7:0] == px[7:0] + py[7:0]) else $error("ramp value wrong");
endmodule // vsdc_properties

bind vsdc_top vsdc_properties #(.DW(DW), .INIT_CYCLES(INIT_CYCLES)) u_props (.ref_clk, .rst_b, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .s_axis_tdata,
	.s_axis_tvalid, .s_axis_tready, .s_axis_tlast, .s_axis_tuser, .m_axis_tdata, .m_axis_tvalid, .m_axis_tready,
	.m_axis_tlast, .m_axis_tuser);

/* verification/vsdc_stream_partner.sv */
// Upstream video source and stalling downstream sink
`timescale 1ns/1ps
module vsdc_stream_partner #(
	parameter DW = 8
) (
	input  logic          ref_clk,
	output logic [DW-1:0] tdata,
	output logic          tvalid,
	input  logic          tready,
	output logic          tlast,
	output logic          tuser,
	input  logic          stall_en,
	output logic          m_ready
);
	logic [7:0] lfsr = 8'hA5;
	initial begin
		tdata  = '0;
		tvalid = 1'b0;
		tlast  = 1'b0;
		tuser  = 1'b0;
	end
	// Sink stalls about one cycle in four
	always @(posedge ref_clk)
		lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
	assign m_ready = !stall_en || lfsr[1:0] != 2'h0;
	task automatic send_line(input int n, input logic start, input logic ends, input logic [DW-1:0] base);
		int w;
		for (int i = 0; i < n; i++) begin
			tdata  <= base + DW'(i);
			tvalid <= 1'b1;
			tuser  <= start && i == 0;
			tlast  <= ends && i == n - 1;
			w = 0;
			do begin @(posedge ref_clk); w++; end while (tready !== 1'b1 && w < 100000);
		end
		// Released data flips so stale values never pass
		tvalid <= 1'b0;
		tuser  <= 1'b0;
		tlast  <= 1'b0;
		tdata  <= ~tdata;
		@(posedge ref_clk);
	endtask
endmodule // vsdc_stream_partner

/* verification/vsdc_top_tb.sv */
// Self-checking bench of the video stream debug checker
`timescale 1ns/1ps
`include "vsdc_map.vh"
module vsdc_top_tb;
	localparam int INIT = 8;
	logic        ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, stall_en;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0]  avs_byteenable;
	logic [7:0]  s_axis_tdata;
	logic        s_axis_tvalid, s_axis_tready, s_axis_tlast, s_axis_tuser;
	logic [23:0] m_axis_tdata;
	logic        m_axis_tvalid, m_axis_tready, m_axis_tlast, m_axis_tuser;
	logic [25:0] expq[$];
	int          err_count, checks_done, nbeat, mode, px, py, hs, vs;
	vsdc_top #(.DW(8), .INCLUDE_DEBUG(1), .INIT_CYCLES(INIT)) dut (.ref_clk, .rst_b, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .s_axis_tdata, .s_axis_tvalid,
		.s_axis_tready, .s_axis_tlast, .s_axis_tuser, .m_axis_tdata, .m_axis_tvalid, .m_axis_tready, .m_axis_tlast,
		.m_axis_tuser);
	vsdc_stream_partner #(.DW(8)) part (.ref_clk, .tdata(s_axis_tdata), .tvalid(s_axis_tvalid),
		.tready(s_axis_tready), .tlast(s_axis_tlast), .tuser(s_axis_tuser), .stall_en, .m_ready(m_axis_tready));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ****
	// Checks and bus cycles
	// ****
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 64);
		rd = avs_readdata;
		if (n == 64) chk("bus answer", 32'h0, 32'h1);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		av(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), e, rd);
	endtask
	task automatic line(input int n, input logic start, input logic ends);
		logic [7:0] b;
		b = 8'($urandom);
		if (mode == 1)
			for (int i = 0; i < n; i++) expq.push_back({start && i == 0, ends && i == n - 1, 16'h0000, b + 8'(i)});
		part.send_line(n, start, ends, b);
	endtask
	// One run of two plus rest lines with the second line altered
	task automatic err_case(input int n2, input logic s2, input int rest, input logic [3:0] m, input int nb);
		int n0;
		n0 = nbeat;
		line(8, 1'b1, 1'b1);
		line(n2, s2, 1'b1);
		repeat (rest) line(8, 1'b0, 1'b1);
		repeat (16) @(posedge ref_clk);
		chk("output beats", nb, nbeat - n0);
		av(1'b0, `VSDC_REG_ERROR, 32'h0);
		chk("error flag", m, rd[3:0] & m);
		av(1'b1, `VSDC_REG_ERROR, 32'h0000_000F);
		rchk(`VSDC_REG_ERROR, 32'h0);
		$display("framing case %h done", m);
	endtask
	function automatic logic [23:0] pat(input int x, input int y);
		logic [2:0] c;
		logic [7:0] g;
		c = x[8:6];
		g = 8'(x + y);
		if (y < 256)
			return {{8{c[0]}}, {8{c[2]}}, {8{c[1]}}};
		return {g, g, g};
	endfunction
	task automatic pat_run(input int h, input int v, input logic [31:0] c, input int nb);
		int n0;
		av(1'b1, `VSDC_REG_ACTIVE_SIZE, {3'h0, 13'(v), 3'h0, 13'(h)});
		hs = h;
		vs = v;
		px = 0;
		py = 0;
		av(1'b1, `VSDC_REG_CONTROL, c);
		mode = 2;
		n0 = nbeat;
		rchk(`VSDC_REG_CONTROL, c & 32'h30);
		while (nbeat < n0 + nb) @(posedge ref_clk);
		mode = 0;
		av(1'b1, `VSDC_REG_CONTROL, 32'h0);
		repeat (8) @(posedge ref_clk);
		$display("pattern %0dx%0d done", h, v);
	endtask
	always @(posedge ref_clk) begin
		if (m_axis_tvalid === 1'b1 && m_axis_tready === 1'b1) begin
			nbeat++;
			if (mode == 1)
				chk("pass beat", expq.size() ? expq.pop_front() : 32'hFFFF_FFFF, {m_axis_tuser, m_axis_tlast, m_axis_tdata});
			if (mode == 2) begin
				chk("pattern beat", {px == 0 && py == 0, px == hs - 1, pat(px, py)}, {m_axis_tuser, m_axis_tlast, m_axis_tdata});
				px++;
				if (px == hs) begin
					px = 0;
					py = (py + 1) % vs;
				end
			end
		end
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Whole run needs well under this
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_count++;
		report_and_stop;
	end
	initial begin
		rst_b = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		stall_en = 1'b0;
		void'($urandom(32'h158808DE));
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		rchk(`VSDC_REG_CONTROL, `VSDC_CONTROL_RST);
		rchk(`VSDC_REG_ERROR, 32'h0);
		rchk(`VSDC_REG_ACTIVE_SIZE, `VSDC_ACTIVE_SIZE_RST);
		av(1'b1, 5'h14, 32'hFFFF_FFFF);
		rchk(5'h14, 32'h0);
		av(1'b1, `VSDC_REG_ACTIVE_SIZE, 32'h0004_0008);
		stall_en <= 1'b1;
		repeat (INIT) @(posedge ref_clk);
		$display("registers done");
		nbeat = 0;
		for (int i = 0; i < 4; i++) line(8, i == 0, 1'b1);
		repeat (16) @(posedge ref_clk);
		chk("warm-up beats", 16, nbeat);
		rchk(`VSDC_REG_ERROR, 32'h0);
		rchk(`VSDC_REG_STATUS, 32'h8);
		$display("warm-up done");
		err_case(5, 1'b0, 2, 4'h1, 29);
		err_case(11, 1'b0, 2, 4'h2, 32);
		err_case(8, 1'b1, 2, 4'h4, 32);
		err_case(8, 1'b0, 3, 4'h8, 32);
		av(1'b1, `VSDC_REG_CONTROL, 32'h0000_0010);
		mode = 1;
		repeat (6) line(1 + $urandom % 12, 1'($urandom), 1'($urandom));
		repeat (20) @(posedge ref_clk);
		chk("pass left over", 32'h0, expq.size());
		mode = 0;
		av(1'b1, `VSDC_REG_CONTROL, 32'h0);
		$display("passthrough done");
		pat_run(512, 4, 32'hFFFF_FFFF, 1024);
		pat_run(8, 260, 32'h0000_0020, 2088);
		report_and_stop;
	end
endmodule // vsdc_top_tb
